/* File: logic/swc_irq_ctrl.sv */
// Sticky event status with write-one-to-clear, mask and one level interrupt
module swc_irq_ctrl #(
  parameter int unsigned N = swc_pkg::NUM_EV
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [N-1:0] events,
  input wire logic status_wr,
  input wire logic mask_wr,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  // Set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      status <= '0;
    end else if (status_wr) begin
      status <= (status & ~wdata) | events;
    end else begin
      status <= status | events;
    end
  end

  // Mask register
  always_ff @(posedge clock) begin
    if (rst) begin
      mask <= '0;
    end else if (mask_wr) begin
      mask <= wdata;
    end
  end

  // Level output, registered
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end
endmodule

/* File: logic/swc_ost_timer.sv */
// Oscillator start-up timer: counts a fixed wait and pulses done at its end
module swc_ost_timer #(
  parameter int unsigned CYCLES = swc_pkg::OST_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count;

  // Count from start to the last cycle, then pulse done once
  always_ff @(posedge clock) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        count <= '0;
      end else if (busy) begin
        if (count == LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + CW'(1);
        end
      end
    end
  end
endmodule

/* File: logic/swc_sleep_wake.sv */
// Sleep/wake controller: power-down entry, wake choice and register file
module swc_sleep_wake #(
  parameter int unsigned OST_LEN = swc_pkg::OST_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire swc_pkg::swc_bus_t bus,
  output logic [7:0] rdata,
  input wire logic core_sleep,
  input wire logic [12:0] core_pc,
  input wire swc_pkg::swc_events_t events,
  input wire swc_pkg::swc_resets_t resets,
  output logic prefetch_req,
  output logic [12:0] prefetch_addr,
  output logic cpu_clk_en,
  output logic resume,
  output logic vector_req,
  output logic [12:0] vector_addr,
  output logic device_reset_req,
  output logic wdt_clear,
  output logic wdt_run,
  output logic lfo_run,
  output logic aux_osc_run,
  output logic adc_rc_run,
  output logic cap_sense_run,
  output logic io_hold,
  output logic sleep_nop,
  output logic irq
);
  swc_pkg::swc_state_t state;
  logic [7:0] int_ctrl;
  logic [7:0] pin_flags;
  logic [7:0] peripheral_int_enable_1;
  logic [7:0] peripheral_int_enable_2;
  logic [7:0] peripheral_int_flags_1;
  logic [7:0] peripheral_int_flags_2;
  logic [7:0] status;
  logic [7:0] config_reg;
  logic [swc_pkg::NUM_EV-1:0] ev_status;
  logic [swc_pkg::NUM_EV-1:0] ev_mask;
  logic [swc_pkg::NUM_EV-1:0] ev_pulse;
  logic asleep;
  logic pending;
  logic global_int_enable;
  logic enter;
  logic nop_sleep;
  logic reset_wake;
  logic wdt_wake;
  logic crystal;
  logic ost_start;
  logic ost_busy;
  logic ost_done;
  logic wr_hit_ev;
  logic wr_hit_mask;

  // Any source whose own enable and flag are both set, peripheral sources only while IC_PEIE is set too
  function automatic logic wake_pending(input logic [7:0] ic, input logic [7:0] pf,
                                        input logic [7:0] e1, input logic [7:0] f1,
                                        input logic [7:0] e2, input logic [7:0] f2);
    logic periph;
    periph = |(e1 & f1) | |(e2 & f2 & swc_pkg::PERIPHERAL_INT_ENABLE_2_IMPL);
    wake_pending = (ic[swc_pkg::IC_TMR0_EN] & ic[swc_pkg::IC_TMR0_FLAG])
                 | (ic[swc_pkg::IC_EXT_EN] & ic[swc_pkg::IC_EXT_FLAG])
                 | (ic[swc_pkg::IC_PIN_EN] & (|pf))
                 | (ic[swc_pkg::IC_PEIE] & periph);
  endfunction

  // Decode of sleep entry, wake causes and the register port
  assign global_int_enable = int_ctrl[swc_pkg::IC_GIE];
  assign pending = wake_pending(int_ctrl, pin_flags, peripheral_int_enable_1, peripheral_int_flags_1, peripheral_int_enable_2, peripheral_int_flags_2);
  assign enter = core_sleep && (state == swc_pkg::SWC_RUN) && !nop_sleep;
  assign nop_sleep = core_sleep && (state == swc_pkg::SWC_RUN) && !global_int_enable && pending;
  assign reset_wake = (resets.ext_pin && config_reg[swc_pkg::CFG_PIN_RST_EN])
                    || (resets.brownout && config_reg[swc_pkg::CFG_BROWNOUT_EN])
                    || resets.power_on;
  assign wdt_wake = resets.wdt_timeout && config_reg[swc_pkg::CFG_WDT_EN];
  assign crystal = config_reg[swc_pkg::CFG_OSC_LSB +: 2] != swc_pkg::OSC_INTERNAL;
  assign asleep = (state != swc_pkg::SWC_RUN);
  assign ost_start = (state == swc_pkg::SWC_SLEEP) && !reset_wake && crystal
                   && (pending || wdt_wake);
  assign wr_hit_ev = bus.wr && (bus.addr == swc_pkg::REG_EV_STATUS);
  assign wr_hit_mask = bus.wr && (bus.addr == swc_pkg::REG_EV_MASK);
  assign ev_pulse = {reset_wake && !rst, (state == swc_pkg::SWC_WAKE), nop_sleep, enter};

  // Power-down state machine
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= swc_pkg::SWC_RUN;
    end else if (reset_wake) begin
      state <= swc_pkg::SWC_RUN;
    end else begin
      case (state)
        swc_pkg::SWC_RUN: begin
          if (enter) begin
            state <= swc_pkg::SWC_SLEEP;
          end
        end
        swc_pkg::SWC_SLEEP: begin
          if (pending || wdt_wake) begin
            state <= crystal ? swc_pkg::SWC_OST : swc_pkg::SWC_WAKE;
          end
        end
        swc_pkg::SWC_OST: begin
          if (ost_done) begin
            state <= swc_pkg::SWC_WAKE;
          end
        end
        swc_pkg::SWC_WAKE: begin
          state <= swc_pkg::SWC_RUN;
        end
        default: begin
          state <= swc_pkg::SWC_RUN;
        end
      endcase
    end
  end

  // Processor clock gate follows the power-down state
  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_clk_en <= 1'b1;
    end else if (reset_wake || state == swc_pkg::SWC_WAKE) begin
      cpu_clk_en <= 1'b1;
    end else if (enter) begin
      cpu_clk_en <= 1'b0;
    end
  end

  // Resume, vector and reset requests toward the core
  always_ff @(posedge clock) begin
    if (rst) begin
      resume <= 1'b0;
      vector_req <= 1'b0;
      vector_addr <= swc_pkg::VECTOR_ADDR;
      device_reset_req <= 1'b0;
      sleep_nop <= 1'b0;
    end else begin
      resume <= (state == swc_pkg::SWC_WAKE) && !reset_wake;
      vector_req <= (state == swc_pkg::SWC_WAKE) && !reset_wake && global_int_enable;
      vector_addr <= swc_pkg::VECTOR_ADDR;
      device_reset_req <= reset_wake;
      sleep_nop <= nop_sleep;
    end
  end

  // Prefetch of the instruction after the sleep instruction
  always_ff @(posedge clock) begin
    if (rst) begin
      prefetch_req <= 1'b0;
      prefetch_addr <= '0;
    end else begin
      prefetch_req <= core_sleep && (state == swc_pkg::SWC_RUN);
      if (core_sleep) begin
        prefetch_addr <= core_pc + swc_pkg::PC_STEP;
      end
    end
  end

  // Watchdog clear on entry and on each pass through SWC_WAKE; no clear for a no-op sleep or a reset wake
  always_ff @(posedge clock) begin
    if (rst) begin
      wdt_clear <= 1'b0;
      wdt_run <= 1'b0;
    end else begin
      wdt_clear <= enter || (state == swc_pkg::SWC_WAKE);
      wdt_run <= config_reg[swc_pkg::CFG_WDT_EN];
    end
  end

  // Always-on clocks, ADC RC clock from CFG_ADC_RC, and pin hold during power-down
  always_ff @(posedge clock) begin
    if (rst) begin
      lfo_run <= 1'b1;
      aux_osc_run <= 1'b1;
      cap_sense_run <= 1'b1;
      adc_rc_run <= 1'b0;
      io_hold <= 1'b0;
    end else begin
      lfo_run <= 1'b1;
      aux_osc_run <= 1'b1;
      cap_sense_run <= 1'b1;
      adc_rc_run <= config_reg[swc_pkg::CFG_ADC_RC];
      io_hold <= (enter || asleep) && !reset_wake;
    end
  end

  // Power-down and timeout flags; the rest of the status byte is software's
  always_ff @(posedge clock) begin
    if (rst) begin
      status <= swc_pkg::STATUS_RST;
    end else begin
      if (bus.wr && bus.addr == swc_pkg::REG_STATUS) begin
        status[7:5] <= bus.wdata[7:5];
        status[2:0] <= bus.wdata[2:0];
      end
      if (resets.power_on) begin
        status[swc_pkg::ST_TIMEOUT] <= 1'b1;
        status[swc_pkg::ST_PDOWN] <= 1'b1;
      end else if (enter) begin
        status[swc_pkg::ST_PDOWN] <= 1'b0;
        status[swc_pkg::ST_TIMEOUT] <= 1'b1;
      end else if (wdt_wake && state == swc_pkg::SWC_SLEEP) begin
        status[swc_pkg::ST_TIMEOUT] <= 1'b0;
      end
    end
  end

  // Interrupt control: enables by software, flags set by events win over writes
  always_ff @(posedge clock) begin
    if (rst) begin
      int_ctrl <= swc_pkg::INT_CTRL_RST;
    end else begin
      if (bus.wr && bus.addr == swc_pkg::REG_INT_CTRL) begin
        int_ctrl[7:1] <= bus.wdata[7:1];
      end
      if (events.tmr0) begin
        int_ctrl[swc_pkg::IC_TMR0_FLAG] <= 1'b1;
      end
      if (events.ext_int) begin
        int_ctrl[swc_pkg::IC_EXT_FLAG] <= 1'b1;
      end
      int_ctrl[swc_pkg::IC_PIN_FLAG] <= |(pin_flags | events.pin_change);
    end
  end

  // Flag registers: software writes, hardware events set
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_flags <= swc_pkg::FLAGS_RST;
      peripheral_int_flags_1 <= swc_pkg::FLAGS_RST;
      peripheral_int_flags_2 <= swc_pkg::FLAGS_RST;
    end else begin
      pin_flags <= ((bus.wr && bus.addr == swc_pkg::REG_PIN_FLAGS) ? bus.wdata : pin_flags)
                 | events.pin_change;
      peripheral_int_flags_1 <= ((bus.wr && bus.addr == swc_pkg::REG_PERIPHERAL_INT_FLAGS_1) ? bus.wdata : peripheral_int_flags_1)
            | events.periph_1;
      peripheral_int_flags_2 <= (((bus.wr && bus.addr == swc_pkg::REG_PERIPHERAL_INT_FLAGS_2) ? bus.wdata : peripheral_int_flags_2)
            | events.periph_2) & swc_pkg::PERIPHERAL_INT_ENABLE_2_IMPL;
    end
  end

  // Enable and configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      peripheral_int_enable_1 <= swc_pkg::FLAGS_RST;
      peripheral_int_enable_2 <= swc_pkg::FLAGS_RST;
      config_reg <= swc_pkg::CONFIG_RST;
    end else if (bus.wr) begin
      case (bus.addr)
        swc_pkg::REG_PERIPHERAL_INT_ENABLE_1: peripheral_int_enable_1 <= bus.wdata;
        swc_pkg::REG_PERIPHERAL_INT_ENABLE_2: peripheral_int_enable_2 <= bus.wdata & swc_pkg::PERIPHERAL_INT_ENABLE_2_IMPL;
        swc_pkg::REG_CONFIG: config_reg <= bus.wdata;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the read strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (rst || !bus.rd) begin
      rdata <= '0;
    end else begin
      case (bus.addr)
        swc_pkg::REG_INT_CTRL: rdata <= int_ctrl;
        swc_pkg::REG_PIN_FLAGS: rdata <= pin_flags;
        swc_pkg::REG_PERIPHERAL_INT_ENABLE_1: rdata <= peripheral_int_enable_1;
        swc_pkg::REG_PERIPHERAL_INT_ENABLE_2: rdata <= peripheral_int_enable_2;
        swc_pkg::REG_PERIPHERAL_INT_FLAGS_1: rdata <= peripheral_int_flags_1;
        swc_pkg::REG_PERIPHERAL_INT_FLAGS_2: rdata <= peripheral_int_flags_2;
        swc_pkg::REG_STATUS: rdata <= status;
        swc_pkg::REG_EV_STATUS: rdata <= {4'h0, ev_status};
        swc_pkg::REG_EV_MASK: rdata <= {4'h0, ev_mask};
        swc_pkg::REG_CONFIG: rdata <= config_reg;
        default: rdata <= '0;
      endcase
    end
  end

  // Start-up wait for the crystal modes
  swc_ost_timer #(
    .CYCLES(OST_LEN)
  ) u_ost (
    .clock(clock),
    .rst(rst || reset_wake),
    .start(ost_start),
    .busy(ost_busy),
    .done(ost_done)
  );

  // Event interrupts
  swc_irq_ctrl #(
    .N(swc_pkg::NUM_EV)
  ) u_irq (
    .clock(clock),
    .rst(rst),
    .events(ev_pulse),
    .status_wr(wr_hit_ev),
    .mask_wr(wr_hit_mask),
    .wdata(bus.wdata[swc_pkg::NUM_EV-1:0]),
    .status(ev_status),
    .mask(ev_mask),
    .irq(irq)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_sleep_only_instr: assert property (
    $rose(state == swc_pkg::SWC_SLEEP) |-> $past(core_sleep))
    else $error("power-down entered without a sleep instruction");

  a_entry_flags: assert property (
    enter && !reset_wake |=> !status[swc_pkg::ST_PDOWN]
      && status[swc_pkg::ST_TIMEOUT] && !cpu_clk_en)
    else $error("entry did not update flags or stop the cpu clock");

  a_entry_wdt_clear: assert property (
    enter |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog not cleared once on entry");

  a_nop_keeps_flags: assert property (
    nop_sleep && !reset_wake && !resets.wdt_timeout |=> $stable(status[swc_pkg::ST_PDOWN])
      && !wdt_clear && sleep_nop && state == swc_pkg::SWC_RUN)
    else $error("no-op sleep changed state");

  a_prefetch_next: assert property (
    core_sleep && state == swc_pkg::SWC_RUN |=> prefetch_req
      && prefetch_addr == $past(core_pc) + swc_pkg::PC_STEP)
    else $error("wrong prefetch address");

  a_osc_kept: assert property (
    state == swc_pkg::SWC_SLEEP |-> lfo_run && aux_osc_run && cap_sense_run)
    else $error("always-on oscillator stopped in power-down");

  a_pins_held: assert property (
    state == swc_pkg::SWC_SLEEP && $past(state == swc_pkg::SWC_SLEEP) |-> io_hold)
    else $error("pins released during power-down");

  a_ost_clock_off: assert property (
    state == swc_pkg::SWC_OST |-> !cpu_clk_en)
    else $error("cpu clock back before start-up wait ended");

  a_wake_vector: assert property (
    resume |-> vector_req == $past(global_int_enable) && vector_addr == swc_pkg::VECTOR_ADDR)
    else $error("wrong vector choice after wake");

  a_wake_wdt: assert property (
    resume |-> wdt_clear && cpu_clk_en)
    else $error("wake without watchdog clear");

  a_reset_wake: assert property (
    reset_wake |=> device_reset_req && !resume && state == swc_pkg::SWC_RUN)
    else $error("reset source did not reset the device");

  c_sleep_entry: cover property (enter ##[1:20] resume);
  c_nop_sleep: cover property (nop_sleep);
  c_ost_wake: cover property (state == swc_pkg::SWC_OST ##1 ost_busy);
  c_vector_wake: cover property (vector_req);
endmodule

/* File: shared/swc_pkg.sv */
// Package: register map, field layout, timing and carrier types of the sleep/wake controller
package swc_pkg;
  // Register indexes (8-bit registers on the plain port)
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_INT_CTRL = 4'h0;
  localparam logic [3:0] REG_PIN_FLAGS = 4'h1;
  localparam logic [3:0] REG_PERIPHERAL_INT_ENABLE_1 = 4'h2;
  localparam logic [3:0] REG_PERIPHERAL_INT_ENABLE_2 = 4'h3;
  localparam logic [3:0] REG_PERIPHERAL_INT_FLAGS_1 = 4'h4;
  localparam logic [3:0] REG_PERIPHERAL_INT_FLAGS_2 = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_EV_STATUS = 4'h7;
  localparam logic [3:0] REG_EV_MASK = 4'h8;
  localparam logic [3:0] REG_CONFIG = 4'h9;
  // interrupt_control fields
  localparam int unsigned IC_GIE = 7;
  localparam int unsigned IC_PEIE = 6;
  localparam int unsigned IC_TMR0_EN = 5;
  localparam int unsigned IC_EXT_EN = 4;
  localparam int unsigned IC_PIN_EN = 3;
  localparam int unsigned IC_TMR0_FLAG = 2;
  localparam int unsigned IC_EXT_FLAG = 1;
  localparam int unsigned IC_PIN_FLAG = 0;
  // core_status fields
  localparam int unsigned ST_TIMEOUT = 4;
  localparam int unsigned ST_PDOWN = 3;
  // Own configuration fields
  localparam int unsigned CFG_WDT_EN = 0;
  localparam int unsigned CFG_PIN_RST_EN = 1;
  localparam int unsigned CFG_BROWNOUT_EN = 2;
  localparam int unsigned CFG_ADC_RC = 3;
  localparam int unsigned CFG_OSC_LSB = 4;
  // Reset values
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] CONFIG_RST = 8'h06;
  localparam logic [7:0] PERIPHERAL_INT_ENABLE_2_IMPL = 8'hf1;
  // Oscillator modes; the crystal modes need a start-up wait
  localparam logic [1:0] OSC_INTERNAL = 2'h0;
  localparam logic [1:0] OSC_CRYSTAL_LOW = 2'h1;
  localparam logic [1:0] OSC_CRYSTAL_MID = 2'h2;
  localparam logic [1:0] OSC_CRYSTAL_HIGH = 2'h3;
  // Event bits of the interrupt status register
  localparam int unsigned NUM_EV = 4;
  localparam int unsigned EV_SLEPT = 0;
  localparam int unsigned EV_NOP = 1;
  localparam int unsigned EV_WOKE = 2;
  localparam int unsigned EV_RESET = 3;
  // Timing: start-up wait in oscillator periods, oscillator equals the block clock
  localparam int unsigned OST_TOSC = 1024;
  localparam int unsigned OSC_PERIOD_NS = 25;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned OST_CYCLES =
    (OST_TOSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PC_W = 13;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  localparam logic [12:0] PC_STEP = 13'h0001;

  typedef enum logic [3:0] {
    SWC_RUN = 4'b0001,
    SWC_SLEEP = 4'b0010,
    SWC_OST = 4'b0100,
    SWC_WAKE = 4'b1000
  } swc_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } swc_bus_t;

  typedef struct packed {
    logic tmr0;
    logic ext_int;
    logic [7:0] pin_change;
    logic [7:0] periph_1;
    logic [7:0] periph_2;
  } swc_events_t;

  typedef struct packed {
    logic ext_pin;
    logic brownout;
    logic power_on;
    logic wdt_timeout;
  } swc_resets_t;
endpackage

/* File: verif/swc_core_model.sv */
// Far-side model: processor core issuing sleep, plus the watchdog counter
module swc_core_model #(
  parameter int unsigned WDT_LIM = 30
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [12:0] go_pc,
  input wire logic cpu_clk_en,
  input wire logic done,
  input wire logic wdt_run,
  input wire logic wdt_clear,
  output logic core_sleep,
  output logic [12:0] core_pc,
  output logic wdt_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic waiting;
  logic issue;
  logic [7:0] wcnt;
  // One sleep at a time, only while the core clock runs
  assign issue = go && cpu_clk_en && !waiting;
  // Core: pc toggles when not sampled so stale values never look valid
  always_ff @(posedge clock) begin
    if (rst) begin
      core_sleep <= 1'b0;
      waiting <= 1'b0;
      core_pc <= 13'h0000;
    end else begin
      core_sleep <= issue;
      core_pc <= issue ? go_pc : ~core_pc;
      if (issue) begin
        waiting <= 1'b1;
      end else if (done) begin
        waiting <= 1'b0;
      end
    end
  end
  // Watchdog: counts while enabled, restarts on clear, pulses at its limit
  always_ff @(posedge clock) begin
    if (rst || wdt_clear || !wdt_run) begin
      wcnt <= 8'h00;
      wdt_timeout <= 1'b0;
    end else begin
      wcnt <= (wcnt == 8'(WDT_LIM - 1)) ? 8'h00 : wcnt + 8'h01;
      wdt_timeout <= (wcnt == 8'(WDT_LIM - 1));
    end
  end
endmodule

/* File: verif/tb_top.sv */
// Testbench: register-port and sleep/wake sequences with expected values
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned OST = 8;
  localparam swc_pkg::swc_events_t EV_EXT = 26'h1000000;
  localparam swc_pkg::swc_events_t EV_TMR0 = 26'h2000000;
  logic clock = 1'b0;
  logic rst = 1'b1;
  swc_pkg::swc_bus_t bus = '0;
  swc_pkg::swc_events_t events = '0;
  swc_pkg::swc_resets_t resets;
  logic [2:0] rsrc = 3'h0;
  logic go = 1'b0;
  logic [12:0] go_pc = 13'h0000;
  logic [7:0] rdata, rv;
  logic [12:0] core_pc, prefetch_addr, vector_addr;
  logic core_sleep, wdt_to, prefetch_req, cpu_clk_en, resume, vector_req;
  logic device_reset_req, wdt_clear, wdt_run, lfo_run, aux_osc_run;
  logic adc_rc_run, cap_sense_run, io_hold, sleep_nop, irq;
  int err_count = 0;
  int n_compared = 0;

  // Clock and reset-source bundle
  always #12.5ns clock = ~clock;
  assign resets = {rsrc, wdt_to};

  swc_sleep_wake #(.OST_LEN(OST)) DUT (
    .clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
    .core_sleep(core_sleep), .core_pc(core_pc), .events(events), .resets(resets),
    .prefetch_req(prefetch_req), .prefetch_addr(prefetch_addr), .cpu_clk_en(cpu_clk_en),
    .resume(resume), .vector_req(vector_req), .vector_addr(vector_addr),
    .device_reset_req(device_reset_req), .wdt_clear(wdt_clear), .wdt_run(wdt_run),
    .lfo_run(lfo_run), .aux_osc_run(aux_osc_run), .adc_rc_run(adc_rc_run),
    .cap_sense_run(cap_sense_run), .io_hold(io_hold), .sleep_nop(sleep_nop), .irq(irq)
  );

  swc_core_model MDL (
    .clock(clock), .rst(rst), .go(go), .go_pc(go_pc), .cpu_clk_en(cpu_clk_en),
    .done(resume | sleep_nop | device_reset_req), .wdt_run(wdt_run),
    .wdt_clear(wdt_clear), .core_sleep(core_sleep), .core_pc(core_pc),
    .wdt_timeout(wdt_to)
  );

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    @(negedge clock);
    rv = rdata;
    check(16'(rv), 16'(e));
  endtask

  // Ends off the edge so that outputs read next have settled
  task automatic ev(input swc_pkg::swc_events_t e);
    @(posedge clock);
    events <= e;
    @(posedge clock);
    events <= '0;
    @(negedge clock);
  endtask

  task automatic rs(input logic [2:0] v);
    @(posedge clock);
    rsrc <= v;
    @(posedge clock);
    rsrc <= 3'h0;
    @(negedge clock);
  endtask

  // Ask the core to sleep; returns in the cycle after the sleep is taken
  task automatic sleep_go(input logic [12:0] pc);
    @(posedge clock);
    go <= 1'b1;
    go_pc <= pc;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    @(negedge clock);
  endtask

  // Wait for resume; lat counts cycles from the one after the sleep
  task automatic wait_res(input int lat, input logic vec);
    int n;
    n = 0;
    while (resume !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    if (lat > 0) check(16'(n), 16'(lat));
    check(16'({resume, vector_req, wdt_clear, cpu_clk_en, device_reset_req}),
          {11'h0, 1'b1, vec, 3'h6});
  endtask

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #500us;
    err_count++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rdc(swc_pkg::REG_STATUS, 8'h18);
    rdc(swc_pkg::REG_CONFIG, 8'h06);
    rdc(4'hf, 8'h00);
    check(16'({cpu_clk_en, lfo_run, aux_osc_run, cap_sense_run, io_hold, adc_rc_run, wdt_run}),
          16'h78);
    // Pending enabled flag with global enable clear: sleep does nothing
    wr(swc_pkg::REG_INT_CTRL, 8'h10);
    ev(EV_EXT);
    sleep_go(13'h0040);
    check(16'({sleep_nop, cpu_clk_en, wdt_clear, io_hold}), 16'hc);
    rdc(swc_pkg::REG_STATUS, 8'h18);
    // Real sleep, disabled source ignored, enabled source wakes in line
    wr(swc_pkg::REG_INT_CTRL, 8'h10);
    sleep_go(13'h0100);
    check(16'({prefetch_req, cpu_clk_en, wdt_clear, io_hold}), 16'hb);
    check(16'(prefetch_addr), 16'h0101);
    rdc(swc_pkg::REG_STATUS, 8'h10);
    ev(EV_TMR0);
    repeat (4) @(negedge clock);
    check(16'({cpu_clk_en, io_hold, lfo_run, aux_osc_run}), 16'h7);
    ev(EV_EXT);
    wait_res(0, 1'b0);
    // Every oscillator mode, flag set at entry with global enable set
    for (int m = 0; m < 4; m++) begin
      wr(swc_pkg::REG_CONFIG, 8'h06 | 8'(m << 4));
      wr(swc_pkg::REG_INT_CTRL, 8'h90);
      ev(EV_EXT);
      sleep_go(13'h0200);
      check(16'(cpu_clk_en), 16'h0);
      // Crystal: the start-up count plus one cycle for its done pulse to reach the wake state
      wait_res((m == 0) ? 2 : 3 + OST, 1'b1);
      check(16'(vector_addr), 16'h0004);
      rdc(swc_pkg::REG_STATUS, 8'h10);
      wr(swc_pkg::REG_INT_CTRL, 8'h00);
    end
    // Watchdog time-out wakes and clears the timeout flag
    wr(swc_pkg::REG_CONFIG, 8'h0f);
    sleep_go(13'h0300);
    check(16'({wdt_run, adc_rc_run, cpu_clk_en}), 16'h6);
    wait_res(0, 1'b0);
    rdc(swc_pkg::REG_STATUS, 8'h00);
    // Disabled pin reset ignored, brownout resets
    wr(swc_pkg::REG_CONFIG, 8'h04);
    sleep_go(13'h0400);
    rs(3'h4);
    repeat (2) @(negedge clock);
    check(16'({device_reset_req, cpu_clk_en}), 16'h0);
    rs(3'h2);
    check(16'({device_reset_req, cpu_clk_en}), 16'h3);
    wr(swc_pkg::REG_CONFIG, 8'h06);
    sleep_go(13'h0500);
    rs(3'h4);
    check(16'({device_reset_req, cpu_clk_en}), 16'h3);
    // Event status, mask and level interrupt
    check(16'(irq), 16'h0);
    rdc(swc_pkg::REG_EV_STATUS, 8'h0f);
    wr(swc_pkg::REG_EV_MASK, 8'h04);
    repeat (2) @(negedge clock);
    check(16'(irq), 16'h1);
    wr(swc_pkg::REG_EV_STATUS, 8'h0f);
    repeat (2) @(negedge clock);
    check(16'(irq), 16'h0);
    rdc(swc_pkg::REG_EV_STATUS, 8'h00);
    // Power-on reset from sleep restores both status flags
    sleep_go(13'h0600);
    rs(3'h1);
    check(16'({device_reset_req, cpu_clk_en}), 16'h3);
    rdc(swc_pkg::REG_STATUS, 8'h18);
    // Peripheral source wakes only with its own enable and the peripheral gate
    wr(swc_pkg::REG_PERIPHERAL_INT_ENABLE_2, 8'hff);
    rdc(swc_pkg::REG_PERIPHERAL_INT_ENABLE_2, 8'hf1);
    wr(swc_pkg::REG_PERIPHERAL_INT_ENABLE_1, 8'h01);
    wr(swc_pkg::REG_INT_CTRL, 8'h40);
    sleep_go(13'h0700);
    ev(26'h0000200); // Flag bit 1 of the first peripheral group, not enabled
    repeat (3) @(negedge clock);
    check(16'({cpu_clk_en, io_hold}), 16'h1);
    rdc(swc_pkg::REG_PERIPHERAL_INT_FLAGS_1, 8'h02);
    ev(26'h0000100); // Flag bit 0 of the first peripheral group, enabled
    wait_res(0, 1'b0);
    conclude();
  end
endmodule
